/* verilog/pbs_pkg.sv */
package pbs_pkg;

  // ****************************************
  // timebase and interval figures
  // ****************************************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned T_STATUS_MS   = 50;
  localparam int unsigned T_LONG_MS     = 400;
  localparam int unsigned T_PDN_MS      = 1000;
  localparam int unsigned T_PUP_MS      = 5000;
  localparam int unsigned T_HARD_MS     = 5000;
  localparam int unsigned T_WAKE_MS     = 50;
  localparam int unsigned T_TIMEOUT_MS  = 14;
  localparam int unsigned T_EN_US       = 200;
  localparam int unsigned C_STATUS      = T_STATUS_MS * CYC_PER_MS;
  localparam int unsigned C_LONG        = T_LONG_MS * CYC_PER_MS;
  localparam int unsigned C_PDN         = T_PDN_MS * CYC_PER_MS;
  localparam int unsigned C_PUP         = T_PUP_MS * CYC_PER_MS;
  localparam int unsigned C_HARD        = T_HARD_MS * CYC_PER_MS;
  localparam int unsigned C_WAKE        = T_WAKE_MS * CYC_PER_MS;
  localparam int unsigned C_TIMEOUT     = T_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned C_EN          = T_EN_US * CYC_PER_US;

  // ****************************************
  // regulator enables and command register
  // ****************************************
  localparam int unsigned N_REG         = 7;
  localparam int unsigned OE_SW_BIT     = 7;
  localparam logic [7:0]  OE_RESET      = 8'h00;
  localparam logic        DISCH_DEFAULT = 1'h0;

  typedef logic [31:0] pbs_cnt_t;
  localparam pbs_cnt_t CNT_MAX = 32'hFFFFFFFF;

  typedef enum logic [1:0] {
    POWER_DOWN_STATE,
    OFF_STATE,
    POWER_UP_STATE,
    POWER_ON_STATE
  } pbs_state_e;

  // conditioned button view
  typedef struct packed {
    logic pressed;
    logic long_press_event;
    logic hard_hold;
    logic status_n;
  } pbs_btn_s;

  // fault sources that force a shutdown
  typedef struct packed {
    logic low_supply;
    logic over_temp;
    logic rail_timeout;
  } pbs_fault_s;

endpackage

/* verilog/pbs_button.sv */
module pbs_button #(
  parameter pbs_pkg::pbs_cnt_t STATUS_CYC = pbs_pkg::pbs_cnt_t'(pbs_pkg::C_STATUS),
  parameter pbs_pkg::pbs_cnt_t LONG_CYC   = pbs_pkg::pbs_cnt_t'(pbs_pkg::C_LONG),
  parameter pbs_pkg::pbs_cnt_t HARD_CYC   = pbs_pkg::pbs_cnt_t'(pbs_pkg::C_HARD)
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             button_n_i,
  output pbs_pkg::pbs_btn_s     btn_o
);

  logic              sync_a;
  logic              sync_b;
  pbs_pkg::pbs_cnt_t press_cnt;
  pbs_pkg::pbs_cnt_t low_cnt;
  logic              status_low;
  logic              hard_pulse;

  // two-flop synchroniser; only sync_b is looked at
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= button_n_i;
      sync_b <= sync_a;
    end
  end

  wire pressed    = ~sync_b;
  wire press_sat  = (press_cnt == HARD_CYC);
  wire min_done   = (low_cnt >= STATUS_CYC);
  wire status_set = pressed && (press_cnt == STATUS_CYC - 32'h1);

  // press length, saturating at the hard-reset figure
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      press_cnt  <= '0;
      hard_pulse <= 1'b0;
    end else begin
      press_cnt  <= !pressed ? '0 : (press_sat ? press_cnt : press_cnt + 32'h1);
      hard_pulse <= pressed && (press_cnt == HARD_CYC - 32'h1);
    end
  end

  // status: low after debounce, held a minimum time, released with button
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_low <= 1'b0;
      low_cnt    <= '0;
    end else begin
      if (status_set) begin
        status_low <= 1'b1;
      end else if (status_low && !pressed && min_done) begin
        status_low <= 1'b0;
      end
      low_cnt <= !status_low ? '0 : (min_done ? low_cnt : low_cnt + 32'h1);
    end
  end

  assign btn_o.pressed          = pressed;
  assign btn_o.long_press_event = pressed && (press_cnt >= LONG_CYC);
  assign btn_o.hard_hold        = hard_pulse;
  assign btn_o.status_n         = ~status_low;

endmodule

/* verilog/pbs_enable_gate.sv */
module pbs_enable_gate #(
  parameter pbs_pkg::pbs_cnt_t EN_CYC = pbs_pkg::pbs_cnt_t'(pbs_pkg::C_EN)
) (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic [pbs_pkg::N_REG-1:0]  req_i,
  input  wire logic [pbs_pkg::N_REG-1:0]  discharged_i,
  input  wire logic                       wait_override_i,
  output logic      [pbs_pkg::N_REG-1:0]  enable_o
);

  // one delay line per regulator
  genvar g;
  generate
    for (g = 0; g < pbs_pkg::N_REG; g++) begin : g_reg
      pbs_pkg::pbs_cnt_t cnt;
      // a rising request is held off until the output has discharged, unless wait_override_i is set
      wire target = req_i[g] && (enable_o[g] || discharged_i[g] || wait_override_i);
      wire differ = (target != enable_o[g]);

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cnt         <= '0;
          enable_o[g] <= 1'b0;
        end else if (!differ) begin
          cnt <= '0;
        end else if (cnt >= EN_CYC - 32'h1) begin
          cnt         <= '0;
          enable_o[g] <= target;
        end else begin
          cnt <= cnt + 32'h1;
        end
      end
    end
  endgenerate

endmodule

/* verilog/pbs_sequencer.sv */
module pbs_sequencer #(
  parameter bit          SKIP_START     = 1'b0,
  parameter int unsigned STATUS_CYCLES  = pbs_pkg::C_STATUS,
  parameter int unsigned LONG_CYCLES    = pbs_pkg::C_LONG,
  parameter int unsigned PDN_CYCLES     = pbs_pkg::C_PDN,
  parameter int unsigned PUP_CYCLES     = pbs_pkg::C_PUP,
  parameter int unsigned HARD_CYCLES    = pbs_pkg::C_HARD,
  parameter int unsigned WAKE_CYCLES    = pbs_pkg::C_WAKE,
  parameter int unsigned TIMEOUT_CYCLES = pbs_pkg::C_TIMEOUT,
  parameter int unsigned EN_CYCLES      = pbs_pkg::C_EN
) (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       button_n_i,
  input  wire logic                       host_power_hold_i,
  input  wire logic                       always_on_good_i,
  input  wire logic                       rails_good_i,
  input  wire logic                       low_supply_i,
  input  wire logic                       over_temp_i,
  input  wire logic                       timeout_mask_i,
  input  wire logic                       discharge_override_i,
  input  wire logic [pbs_pkg::N_REG-1:0]  regulator_enable_pin_i,
  input  wire logic [pbs_pkg::N_REG-1:0]  discharged_i,
  input  wire logic [pbs_pkg::N_REG-1:0]  keep_alive_i,
  input  wire logic                       oe_write_i,
  input  wire logic [7:0]                 oe_wdata_i,
  output logic      [7:0]                 output_enable_reg_o,
  output logic      [pbs_pkg::N_REG-1:0]  reg_enable_o,
  output logic                            wake_o,
  output logic                            wake_oe_o,
  output logic                            reset_out_n_o,
  output logic                            reset_out_n_oe_o,
  output logic                            button_status_n_o,
  output logic                            cmd_reset_o,
  output logic                            timeout_fault_o,
  output logic      [1:0]                 state_o
);

  // ****************************************
  // local counts
  // ****************************************
  localparam pbs_pkg::pbs_cnt_t PDN_CYC  = pbs_pkg::pbs_cnt_t'(PDN_CYCLES);
  localparam pbs_pkg::pbs_cnt_t PUP_CYC  = pbs_pkg::pbs_cnt_t'(PUP_CYCLES);
  localparam pbs_pkg::pbs_cnt_t WAKE_CYC = pbs_pkg::pbs_cnt_t'(WAKE_CYCLES);
  localparam pbs_pkg::pbs_cnt_t TOUT_CYC = pbs_pkg::pbs_cnt_t'(TIMEOUT_CYCLES);

  // ****************************************
  // state and registers
  // ****************************************
  pbs_pkg::pbs_state_e state;
  pbs_pkg::pbs_state_e next_state;
  pbs_pkg::pbs_cnt_t   tmr;
  pbs_pkg::pbs_cnt_t   next_tmr;
  pbs_pkg::pbs_cnt_t   rail_cnt;
  pbs_pkg::pbs_btn_s   btn;
  pbs_pkg::pbs_fault_s fault;
  logic                start_done;
  logic                button_reset;
  logic                next_button_reset;
  logic                pup_by_button;
  logic                next_pup_by_button;
  logic                off_pending;
  logic                next_off_pending;
  logic                shutdown;
  logic                soft_off;
  logic [7:0]          oe_reg;
  logic                wake_high;
  logic                rst_pull_low;
  logic                cmd_pulse;
  logic                status_n;

  // ****************************************
  // button conditioning
  // ****************************************
  pbs_button #(
    .STATUS_CYC (pbs_pkg::pbs_cnt_t'(STATUS_CYCLES)),
    .LONG_CYC   (pbs_pkg::pbs_cnt_t'(LONG_CYCLES)),
    .HARD_CYC   (pbs_pkg::pbs_cnt_t'(HARD_CYCLES))
  ) u_button (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .button_n_i (button_n_i),
    .btn_o      (btn)
  );

  // ****************************************
  // fault sources
  // ****************************************
  wire in_pdn  = (state == pbs_pkg::POWER_DOWN_STATE);
  wire in_off  = (state == pbs_pkg::OFF_STATE);
  wire in_pup  = (state == pbs_pkg::POWER_UP_STATE);
  wire in_pon  = (state == pbs_pkg::POWER_ON_STATE);
  wire rail_sat = (rail_cnt == TOUT_CYC);

  // rails-low time only matters once the system is up
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rail_cnt <= '0;
    end else begin
      rail_cnt <= (!in_pon || rails_good_i) ? '0 : (rail_sat ? rail_cnt : rail_cnt + 32'h1);
    end
  end

  // a saturated count lingers one cycle after the rails recover; only a
  // still-low rail may raise the fault, or unmasking would trip it
  assign fault.rail_timeout = rail_sat && !rails_good_i && !timeout_mask_i;
  assign fault.low_supply   = low_supply_i;
  assign fault.over_temp    = over_temp_i;
  wire   any_fault          = |fault;

  // ****************************************
  // power sequence decisions
  // ****************************************
  // hard reset by press or fault; power-up is left alone by the press so
  // the press that woke the system does not also reset it
  wire hard_press  = in_pon && btn.hard_hold;
  wire fault_stop  = (in_pup || in_pon) && any_fault;
  wire tmr_sat     = (tmr == pbs_pkg::CNT_MAX);
  wire pdn_done    = in_pdn && (tmr >= PDN_CYC - 32'h1);
  wire pup_done    = in_pup && (tmr >= PUP_CYC - 32'h1);
  wire off_done    = in_pon && off_pending && (tmr >= WAKE_CYC - 32'h1);
  wire start_req   = btn.long_press_event || host_power_hold_i;

  always_comb begin
    next_state         = state;
    next_tmr           = tmr_sat ? tmr : tmr + 32'h1;
    next_button_reset  = button_reset;
    next_pup_by_button = pup_by_button;
    next_off_pending   = off_pending;
    shutdown           = 1'b0;
    soft_off           = 1'b0;
    unique case (state)
      pbs_pkg::POWER_DOWN_STATE: begin
        // inputs are not looked at until the timer ends
        if (pdn_done) begin
          next_button_reset = 1'b0;
          if (host_power_hold_i && !any_fault && start_done) begin
            next_state         = pbs_pkg::POWER_UP_STATE;
            next_pup_by_button = 1'b0;
          end else begin
            next_state = pbs_pkg::OFF_STATE;
          end
        end
      end
      pbs_pkg::OFF_STATE: begin
        if (start_req) begin
          next_state         = pbs_pkg::POWER_UP_STATE;
          next_pup_by_button = btn.long_press_event;
        end
      end
      pbs_pkg::POWER_UP_STATE: begin
        if (fault_stop) begin
          next_state = pbs_pkg::POWER_DOWN_STATE;
          shutdown   = 1'b1;
        end else if (pup_done) begin
          // without the host's confirmation, pass on to power-down
          next_state = host_power_hold_i ? pbs_pkg::POWER_ON_STATE
                                         : pbs_pkg::POWER_DOWN_STATE;
        end
      end
      pbs_pkg::POWER_ON_STATE: begin
        if (hard_press || fault_stop) begin
          next_state        = pbs_pkg::POWER_DOWN_STATE;
          next_button_reset = hard_press;
          next_off_pending  = 1'b0;
          shutdown          = 1'b1;
        end else if (off_done) begin
          next_state       = pbs_pkg::POWER_DOWN_STATE;
          next_off_pending = 1'b0;
          soft_off         = 1'b1;
        end else if (!off_pending) begin
          next_tmr         = '0;
          next_off_pending = !host_power_hold_i;
        end
      end
    endcase
    if (next_state != state) begin
      next_tmr = '0;
    end
  end

  // single timebase counter shared by the power-down, power-up and wake intervals
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= SKIP_START ? pbs_pkg::OFF_STATE : pbs_pkg::POWER_DOWN_STATE;
      tmr   <= '0;
    end else begin
      state <= next_state;
      tmr   <= next_tmr;
    end
  end

  // sequence flags
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      button_reset  <= 1'b0;
      pup_by_button <= 1'b0;
      off_pending   <= 1'b0;
      start_done    <= SKIP_START;
    end else begin
      button_reset  <= next_button_reset;
      pup_by_button <= next_pup_by_button;
      off_pending   <= next_off_pending;
      if (pdn_done) begin
        start_done <= 1'b1;
      end
    end
  end

  // ****************************************
  // output enable command register
  // ****************************************
  // writes during power-down are dropped so a shutdown clear sticks
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe_reg    <= pbs_pkg::OE_RESET;
      cmd_pulse <= 1'b0;
    end else begin
      cmd_pulse <= shutdown;
      if (shutdown || soft_off) begin
        oe_reg <= pbs_pkg::OE_RESET;
      end else if (oe_write_i && !in_pdn) begin
        oe_reg <= oe_wdata_i;
      end
    end
  end

  // ****************************************
  // regulator enable selection
  // ****************************************
  // software mode detaches the pins; keep-alive survives the off state
  wire                      sw_mode = oe_reg[pbs_pkg::OE_SW_BIT];
  wire [pbs_pkg::N_REG-1:0] sel_en  = sw_mode ? oe_reg[pbs_pkg::N_REG-1:0]
                                              : regulator_enable_pin_i;
  wire [pbs_pkg::N_REG-1:0] on_req  = sel_en | keep_alive_i;
  wire [pbs_pkg::N_REG-1:0] req     = in_pdn ? '0
                                    : (in_off ? keep_alive_i : on_req);

  pbs_enable_gate #(
    .EN_CYC (pbs_pkg::pbs_cnt_t'(EN_CYCLES))
  ) u_enable (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .req_i           (req),
    .discharged_i    (discharged_i),
    .wait_override_i (discharge_override_i),
    .enable_o        (reg_enable_o)
  );

  // ****************************************
  // pins
  // ****************************************
  // wake: at once for a button start, after a delay for a hold start
  wire next_wake = (in_pup && !fault_stop && !(pup_done && !host_power_hold_i)
                    && (pup_by_button || tmr >= WAKE_CYC - 32'h1))
                 || (in_pon && !hard_press && !fault_stop && !off_done);

  // reset pin low until start-up and always-on regulator are good,
  // and through the power-down that follows a button hard reset
  wire next_rst_low = !(start_done && always_on_good_i)
                    || (in_pdn && button_reset)
                    || hard_press;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_high    <= 1'b0;
      rst_pull_low <= 1'b1;
      status_n     <= 1'b1;
    end else begin
      wake_high    <= next_wake;
      rst_pull_low <= next_rst_low;
      status_n     <= btn.status_n;
    end
  end

  // open-drain pins only ever pull low
  assign wake_o              = 1'b0;
  assign wake_oe_o           = ~wake_high;
  assign reset_out_n_o       = 1'b0;
  assign reset_out_n_oe_o    = rst_pull_low;
  assign button_status_n_o   = status_n;
  assign output_enable_reg_o = oe_reg;
  assign cmd_reset_o         = cmd_pulse;
  assign timeout_fault_o     = fault.rail_timeout;
  assign state_o             = state;

endmodule

/* tb/pbs_sequencer_props.sv */
module pbs_sequencer_props #(
  parameter int unsigned STATUS_CYCLES = 5,
  parameter int unsigned PDN_CYCLES    = 30,
  parameter int unsigned PUP_CYCLES    = 100
) (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       button_n_i,
  input wire logic       host_power_hold_i,
  input wire logic       always_on_good_i,
  input wire logic       low_supply_i,
  input wire logic       over_temp_i,
  input wire logic [7:0] output_enable_reg_o,
  input wire logic       wake_oe_o,
  input wire logic       reset_out_n_oe_o,
  input wire logic       button_status_n_o,
  input wire logic       cmd_reset_o,
  input wire logic [1:0] state_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // helper counters and checks
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [31:0] st_cnt;
  logic [31:0] lo_cnt;
  logic [1:0]  st_q;
  // age of state and of the status low phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_cnt <= 32'h0;
      lo_cnt <= 32'h0;
      st_q   <= 2'h0;
    end else begin
      st_q   <= state_o;
      st_cnt <= (st_q != state_o) ? 32'h0 : st_cnt + 32'h1;
      lo_cnt <= button_status_n_o ? 32'h0 : lo_cnt + 32'h1;
    end
  end
  pdn_wake_low_a: assert property (state_o == 2'h0 |-> wake_oe_o)
    else $error("wake released in power-down");
  pdn_length_a: assert property ($past(state_o) == 2'h0 && state_o != 2'h0
    |-> $past(st_cnt) >= PDN_CYCLES - 2) else $error("power-down too short");
  off_exit_a: assert property (state_o == 2'h1 |=> state_o inside {2'h1, 2'h2})
    else $error("off left to wrong state");
  button_wake_a: assert property ($past(state_o) == 2'h1 && state_o == 2'h2
    && !$past(button_n_i) |-> ##[0:2] !wake_oe_o) else $error("wake not released");
  hold_wake_a: assert property ($past(state_o) == 2'h1 && state_o == 2'h2
    && $past(button_n_i) |-> wake_oe_o[*3] ##[1:8] !wake_oe_o)
    else $error("hold start wake timing wrong");
  pup_length_a: assert property ($past(state_o) == 2'h2 && state_o != 2'h2
    && !$past(over_temp_i) && !$past(low_supply_i) |-> $past(st_cnt) >= PUP_CYCLES - 2)
    else $error("power-up too short");
  no_hold_pdn_a: assert property ($past(state_o) == 2'h2 && state_o != 2'h2
    && !$past(host_power_hold_i) |-> state_o == 2'h0) else $error("power-up kept on");
  hold_drop_a: assert property (state_o == 2'h3 && !host_power_hold_i
    && button_n_i |-> ##[1:12] state_o == 2'h0) else $error("hold drop ignored");
  hard_rst_out_a: assert property ($past(state_o) == 2'h3 && state_o == 2'h0
    && !$past(button_n_i) && !$past(over_temp_i) && !$past(low_supply_i)
    |-> ##1 reset_out_n_oe_o[*8]) else $error("reset not held on hard reset");
  clear_oe_a: assert property ($past(state_o) != 2'h0 && state_o == 2'h0
    |-> ##1 output_enable_reg_o == 8'h00) else $error("enable register not cleared");
  cmd_pulse_a: assert property (cmd_reset_o |-> state_o == 2'h0 ##1 !cmd_reset_o)
    else $error("command reset pulse wrong");
  rst_ao_a: assert property (!$past(always_on_good_i) |-> reset_out_n_oe_o)
    else $error("reset released while regulator bad");
  status_min_a: assert property ($rose(button_status_n_o) |-> lo_cnt >= STATUS_CYCLES)
    else $error("status low too short");
  status_cause_a: assert property ($fell(button_status_n_o) |-> !$past(button_n_i, 4))
    else $error("status fell without press");
  hold_start_c: cover property ($past(button_n_i) && $past(state_o) == 2'h1 && state_o == 2'h2);
  hard_rst_c: cover property (cmd_reset_o && !button_n_i);
  status_c: cover property ($fell(button_status_n_o));
endmodule
bind pbs_sequencer pbs_sequencer_props #(.STATUS_CYCLES(STATUS_CYCLES),
  .PDN_CYCLES(PDN_CYCLES), .PUP_CYCLES(PUP_CYCLES)) u_props (.clk_i(clk_i),
  .rstn_i(rstn_i), .button_n_i(button_n_i), .host_power_hold_i(host_power_hold_i),
  .always_on_good_i(always_on_good_i), .low_supply_i(low_supply_i),
  .over_temp_i(over_temp_i), .output_enable_reg_o(output_enable_reg_o),
  .wake_oe_o(wake_oe_o), .reset_out_n_oe_o(reset_out_n_oe_o),
  .button_status_n_o(button_status_n_o), .cmd_reset_o(cmd_reset_o), .state_o(state_o));

/* tb/pbs_host_model.sv */
module pbs_host_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [4:0] lat_i,
  input  wire logic       wake_i,
  input  wire logic       status_n_i,
  output logic            hold_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  logic       seen;
  // mode 0 low, 1 confirm, 2 always high, 3 confirm then drop after a press
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_o <= 1'b0;
      cnt    <= 5'h0;
      seen   <= 1'b0;
    end else if (mode_i == 2'h0) begin
      hold_o <= 1'b0;
      seen   <= 1'b0;
    end else if (mode_i == 2'h2) begin
      hold_o <= 1'b1;
    end else if (mode_i == 2'h3 && seen && status_n_i) begin
      hold_o <= 1'b0; // host decides to power down
    end else begin
      seen <= seen | (!status_n_i && mode_i == 2'h3);
      cnt  <= (wake_i && cnt != 5'h1F) ? cnt + 5'h1 : (wake_i ? cnt : 5'h0);
      if (wake_i && cnt >= lat_i) begin
        hold_o <= 1'b1; // confirm rails before power-up ends
      end
    end
  end
endmodule

/* tb/tb_pbs_sequencer.sv */
module tb_pbs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned S = 5, L = 20, P = 30, U = 100, H = 120, W = 5, T = 10;
  logic clk_i = 0, rstn_i = 0, btn_n = 1, ao = 0, rails = 1, low_sup = 0, ovt = 0;
  logic mask = 0, ovr = 0, oe_wr = 0, hold, wake_oe, rst_oe, stat_n, tflt;
  logic [6:0] pins = 0, dis = 0, keep = 0, reg_en;
  logic [7:0] oe_wd = 0, oe_reg;
  logic [1:0] state_o, mode = 0;
  logic [4:0] lat = 5'h3;
  int n_mismatch = 0, check_count = 0;
  // ****************************************
  // clock, device and host
  // ****************************************
  initial forever #5 clk_i = ~clk_i;
  pbs_sequencer #(.STATUS_CYCLES(S), .LONG_CYCLES(L), .PDN_CYCLES(P), .PUP_CYCLES(U),
    .HARD_CYCLES(H), .WAKE_CYCLES(W), .TIMEOUT_CYCLES(T), .EN_CYCLES(4)) u_pbs_sequencer (
    .clk_i(clk_i), .rstn_i(rstn_i), .button_n_i(btn_n), .host_power_hold_i(hold),
    .always_on_good_i(ao), .rails_good_i(rails), .low_supply_i(low_sup), .over_temp_i(ovt),
    .timeout_mask_i(mask), .discharge_override_i(ovr), .regulator_enable_pin_i(pins),
    .discharged_i(dis), .keep_alive_i(keep), .oe_write_i(oe_wr), .oe_wdata_i(oe_wd),
    .output_enable_reg_o(oe_reg), .reg_enable_o(reg_en), .wake_o(), .wake_oe_o(wake_oe),
    .reset_out_n_o(), .reset_out_n_oe_o(rst_oe), .button_status_n_o(stat_n),
    .cmd_reset_o(), .timeout_fault_o(tflt), .state_o(state_o));
  pbs_host_model u_pbs_host_model (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode),
    .lat_i(lat), .wake_i(!wake_oe), .status_n_i(stat_n), .hold_o(hold));
  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // enable pins and discharge flags churn at random every edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      pins <= 7'($urandom);
      dis  <= 7'($urandom);
      keep <= 7'($urandom);
      ovr  <= 1'($urandom);
    end
    #1;
  endtask
  // bounded wait, so a stuck sequencer shows as a mismatch
  task automatic wait_st(input logic [1:0] s, input int lim);
    int i;
    i = 0;
    while (state_o !== s && i < lim) begin
      tick(1);
      i++;
    end
    check("state", 32'(s), 32'(state_o));
  endtask
  task automatic wr_oe(input logic [7:0] v, input logic [7:0] exp);
    oe_wd <= v;
    oe_wr <= 1'b1;
    tick(1);
    oe_wr <= 1'b0;
    tick(1);
    check("oe_reg", 32'(exp), 32'(oe_reg));
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [7:0] v;
    void'($urandom(32'h8A6B));
    tick(10);
    rstn_i <= 1'b1;
    tick(1);
    check("state", 32'h0, 32'(state_o));
    wait_st(2'h1, P + 5);
    check("rst_oe", 32'h1, 32'(rst_oe));
    ao <= 1'b1;
    tick(2);
    check("rst_oe", 32'h0, 32'(rst_oe));
    // button start, host confirms after a random delay
    mode <= 2'h1;
    lat <= 5'($urandom_range(1, 20));
    btn_n <= 1'b0;
    wait_st(2'h2, L + 10);
    tick(2);
    check("wake_oe", 32'h0, 32'(wake_oe));
    check("status", 32'h0, 32'(stat_n));
    btn_n <= 1'b1;
    wait_st(2'h3, U + 5);
    check("status", 32'h1, 32'(stat_n));
    v = 8'($urandom);
    wr_oe(v, v);
    // short press, host answers by dropping the hold
    mode <= 2'h3;
    btn_n <= 1'b0;
    tick(S + 6);
    btn_n <= 1'b1;
    wait_st(2'h0, 40);
    check("wake_oe", 32'h1, 32'(wake_oe));
    wr_oe(8'($urandom), 8'h00);
    wait_st(2'h1, P + 5);
    check("reg_en", 32'h0, 32'(reg_en));
    // hold start
    mode <= 2'h2;
    wait_st(2'h2, 5);
    check("wake_oe", 32'h1, 32'(wake_oe));
    tick(W + 3);
    check("wake_oe", 32'h0, 32'(wake_oe));
    wait_st(2'h3, U + 5);
    wr_oe(8'h7F, 8'h7F);
    // long press hard reset with hold kept high
    btn_n <= 1'b0;
    wait_st(2'h0, H + 10);
    tick(2);
    check("rst_oe", 32'h1, 32'(rst_oe));
    check("oe_reg", 32'h0, 32'(oe_reg));
    btn_n <= 1'b1;
    wait_st(2'h2, P + 5);
    wait_st(2'h3, U + 5);
    // masked rails-low timeout changes nothing
    mask <= 1'b1;
    rails <= 1'b0;
    tick(T + 5);
    check("state", 32'h3, 32'(state_o));
    check("tflt", 32'h0, 32'(tflt));
    rails <= 1'b1;
    mask <= 1'b0;
    for (int f = 0; f < 3; f++) begin
      if (f == 0) ovt <= 1'b1;
      else if (f == 1) low_sup <= 1'b1;
      else rails <= 1'b0;
      wait_st(2'h0, T + 5);
      ovt <= 1'b0;
      low_sup <= 1'b0;
      rails <= 1'b1;
      wait_st(2'h2, P + 5);
      wait_st(2'h3, U + 5);
    end
    // hold dropped, then a start that the host never confirms
    mode <= 2'h0;
    wait_st(2'h0, W + 10);
    wait_st(2'h1, P + 5);
    btn_n <= 1'b0;
    wait_st(2'h2, L + 10);
    btn_n <= 1'b1;
    wait_st(2'h0, U + 5);
    check("wake_oe", 32'h1, 32'(wake_oe));
    finish_test();
  end
endmodule
